//--- logic/rrx_exec.sv
// executor for no-op, software reset, returns and rotate-left-through-carry
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rrx_exec (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  output logic instr_ready_o,
  // call push from the rest of the core
  input wire logic push_i,
  input wire logic [rrx_pkg::PC_W-1:0] push_addr_i,
  // software register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // status outputs
  output logic [rrx_pkg::PC_W-1:0] pc_o,
  output logic [7:0] wreg_o,
  output logic carry_o,
  output logic gie_o,
  output logic sw_reset_o,
  output logic unknown_op_o
);
  typedef struct packed {
    rrx_pkg::rrx_state_e st;
    logic [rrx_pkg::PC_W-1:0] pc;
    logic [7:0] wreg;
    logic [7:0] status;
    logic [7:0] intctl;
    logic [7:0] pwrctl;
    logic [rrx_pkg::SP_W-1:0] sp;
    logic [rrx_pkg::STACK_DEPTH-1:0][rrx_pkg::PC_W-1:0] stack;
    logic ready;
    logic [7:0] rdata;
    logic rd_file;
    logic sw_reset;
    logic unknown;
  } rrx_state_s;

  rrx_state_s s_reg;
  rrx_state_s s_next;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [6:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] rot_val;
  rrx_pkg::rrx_kind_e kind;

  // decode one instruction word into its kind
  function automatic rrx_pkg::rrx_kind_e decode(input logic [13:0] w);
    rrx_pkg::rrx_kind_e k;
    k = rrx_pkg::K_OTHER;
    if (w == rrx_pkg::OP_NOP)
    begin
      k = rrx_pkg::K_NOP;
    end
    else if (w == rrx_pkg::OP_RESET)
    begin
      k = rrx_pkg::K_RESET;
    end
    else if (w == rrx_pkg::OP_RETFI)
    begin
      k = rrx_pkg::K_RETFI;
    end
    else if (w[13:1] == rrx_pkg::OP_RETURN_HI)
    begin
      k = rrx_pkg::K_RETURN;
    end
    else if (w[13:8] == rrx_pkg::OP_RETLIT_HI)
    begin
      k = rrx_pkg::K_RETLIT;
    end
    else if (w[13:8] == rrx_pkg::OP_ROTL_HI)
    begin
      k = rrx_pkg::K_ROTL;
    end
    return k;
  endfunction

  assign kind = decode(instr_i);

  // the file register read is kept combinationally addressed; rotate reads
  // the operand in the previous cycle via the registered memory output
  // so a rotate is accepted only once its operand is presented
  rrx_file_mem u_mem (
    .clk_i(core_clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // rotate value: operand shifted left, old carry into bit 0
  assign rot_val = {mem_rdata[6:0], s_reg.status[rrx_pkg::CARRY_BIT]};

  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.sw_reset = 1'b0;
    s_next.unknown = 1'b0;
    s_next.rd_file = 1'b0;
    mem_we = 1'b0;
    mem_waddr = instr_i[6:0];
    mem_wdata = rot_val;
    mem_raddr = addr_i[6:0];
    // software register writes
    if (wr_i)
    begin
      if (addr_i[7])
      begin
        mem_we = 1'b1;
        mem_waddr = addr_i[6:0];
        mem_wdata = wdata_i;
      end
      else
      begin
        case (addr_i)
          rrx_pkg::REG_WREG: s_next.wreg = wdata_i;
          rrx_pkg::REG_STATUS: s_next.status = wdata_i;
          rrx_pkg::REG_INTCTL: s_next.intctl = wdata_i;
          rrx_pkg::REG_PWRCTL: s_next.pwrctl = wdata_i;
          default: ;
        endcase
      end
    end
    // push from call logic
    if (push_i)
    begin
      s_next.stack[s_reg.sp] = push_addr_i;
      s_next.sp = s_reg.sp + 1'b1;
    end
    case (s_reg.st)
      rrx_pkg::ST_FETCH:
      begin
        // rotate needs the operand: hold it off a cycle to read memory
        if (instr_valid_i && !wr_i && !rd_i)
        begin
          mem_raddr = instr_i[6:0];
        end
        s_next.ready = 1'b0;
        if (instr_valid_i && s_reg.ready)
        begin
          s_next.pc = s_reg.pc + 1'b1;
          case (kind)
            rrx_pkg::K_NOP: ;
            rrx_pkg::K_RESET:
            begin
              s_next = '0;
              s_next.st = rrx_pkg::ST_FETCH;
              s_next.pwrctl = rrx_pkg::PWRCTL_RESET & ~(8'h01 << rrx_pkg::RI_BIT);
              s_next.intctl = rrx_pkg::INTCTL_RESET;
              s_next.status = rrx_pkg::STATUS_RESET;
              s_next.sw_reset = 1'b1;
            end
            rrx_pkg::K_RETFI, rrx_pkg::K_RETURN, rrx_pkg::K_RETLIT:
            begin
              s_next.sp = s_reg.sp - 1'b1;
              s_next.pc = s_reg.stack[s_reg.sp - 1'b1];
              s_next.st = rrx_pkg::ST_RET2;
              if (kind == rrx_pkg::K_RETFI)
              begin
                s_next.intctl[rrx_pkg::GIE_BIT] = 1'b1;
              end
              if (kind == rrx_pkg::K_RETLIT)
              begin
                s_next.wreg = instr_i[7:0];
              end
            end
            rrx_pkg::K_ROTL:
            begin
              s_next.status[rrx_pkg::CARRY_BIT] = mem_rdata[7];
            end
            default: s_next.unknown = 1'b1;
          endcase
          if (kind == rrx_pkg::K_ROTL)
          begin
            // destination bit d sits at bit 7: 1 writes the file register back
            if (instr_i[7] == 1'b1)
            begin
              mem_we = 1'b1; // file destination
            end
            else
            begin
              s_next.wreg = rot_val; // working register destination
            end
          end
        end
        else if (instr_valid_i)
        begin
          s_next.ready = 1'b1;
        end
      end
      rrx_pkg::ST_RET2:
      begin
        s_next.st = rrx_pkg::ST_FETCH; // second cycle of a return
        s_next.ready = 1'b0;
      end
      default: s_next.st = rrx_pkg::ST_FETCH;
    endcase
    // software reads, data registered for the next cycle
    if (rd_i)
    begin
      s_next.rd_file = addr_i[7];
      case (addr_i)
        rrx_pkg::REG_PC: s_next.rdata = s_reg.pc[7:0];
        rrx_pkg::REG_WREG: s_next.rdata = s_reg.wreg;
        rrx_pkg::REG_STATUS: s_next.rdata = s_reg.status;
        rrx_pkg::REG_INTCTL: s_next.rdata = s_reg.intctl;
        rrx_pkg::REG_PWRCTL: s_next.rdata = s_reg.pwrctl;
        rrx_pkg::REG_SP: s_next.rdata = {4'h0, s_reg.sp};
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.pwrctl <= rrx_pkg::PWRCTL_RESET;
      s_reg.intctl <= rrx_pkg::INTCTL_RESET;
      s_reg.status <= rrx_pkg::STATUS_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops, except rdata_o, a mux of memory and register read data
  assign rdata_o = s_reg.rd_file ? mem_rdata : s_reg.rdata;
  assign instr_ready_o = s_reg.ready; // ready is already low through the second return cycle
  assign pc_o = s_reg.pc;
  assign wreg_o = s_reg.wreg;
  assign carry_o = s_reg.status[rrx_pkg::CARRY_BIT];
  assign gie_o = s_reg.intctl[rrx_pkg::GIE_BIT];
  assign sw_reset_o = s_reg.sw_reset;
  assign unknown_op_o = s_reg.unknown;
endmodule
`default_nettype wire

//--- logic/rrx_pkg.sv
// constants, encodings and types for the return/rotate instruction executor
// What this block does
// - software reset: full reset, clear reset-instruction flag
// - interrupt return pops stack, two cycles, no flags
// - interrupt return sets global interrupt enable bit
// - literal return loads literal into working register
// - literal return pops stack into PC, two cycles
// - plain return pops stack, two cycles, no flags
// - rotate left through carry, only carry changes
// - rotate destination bit: 0 working, 1 file
`default_nettype none
package rrx_pkg;
  localparam int PC_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 4;
  localparam int FILE_AW = 7;
  // register offsets of the software port (chosen)
  localparam logic [7:0] REG_PC = 8'h00;
  localparam logic [7:0] REG_WREG = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_INTCTL = 8'h03;
  localparam logic [7:0] REG_PWRCTL = 8'h04;
  localparam logic [7:0] REG_SP = 8'h05;
  localparam logic [7:0] REG_FILE_BASE = 8'h80;
  // field positions
  localparam int CARRY_BIT = 0;
  localparam int GIE_BIT = 7;
  localparam int RI_BIT = 2;
  // reset values
  localparam logic [7:0] PWRCTL_RESET = 8'h04;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // instruction encodings (14-bit words)
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_RESET = 14'h0001;
  localparam logic [13:0] OP_RETFI = 14'h0009;
  localparam logic [12:0] OP_RETURN_HI = 13'h0009; // plain return is 0x0012 or 0x0013, low bit s
  localparam logic [5:0] OP_RETLIT_HI = 6'h34;
  localparam logic [5:0] OP_ROTL_HI = 6'h0d;
  // number of cycles of a return
  localparam int RET_CYCLES = 2;
  typedef enum logic [1:0] {ST_FETCH, ST_RET2} rrx_state_e;
  typedef enum logic [2:0] {K_NOP, K_RESET, K_RETFI, K_RETLIT, K_RETURN, K_ROTL, K_OTHER} rrx_kind_e;
endpackage
`default_nettype wire

//--- logic/rrx_file_mem.sv
// file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rrx_file_mem (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read port
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:127];
  // synchronous write and registered read
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

//--- sim/rrx_exec_properties.sv
// port assertions for the return/rotate executor
`timescale 1ns/1ps
`default_nettype none
module rrx_exec_properties (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic [rrx_pkg::PC_W-1:0] pc_o,
  input wire logic [7:0] wreg_o,
  input wire logic carry_o,
  input wire logic gie_o,
  input wire logic sw_reset_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // taken words, returns and rotates
  logic tk;
  logic ret;
  logic rot;
  assign tk = instr_valid_i & instr_ready_o;
  assign ret = tk & (instr_i == rrx_pkg::OP_RETFI || instr_i == {rrx_pkg::OP_RETURN_HI, 1'b0}
    || instr_i[13:8] == rrx_pkg::OP_RETLIT_HI);
  assign rot = tk & (instr_i[13:8] == rrx_pkg::OP_ROTL_HI);
  nop_pc_a: assert property (tk && instr_i == rrx_pkg::OP_NOP |=> pc_o == $past(pc_o) + 1'b1
    && $stable(wreg_o) && $stable(carry_o)) else $error("nop state wrong");
  ret_gie_a: assert property (tk && instr_i == rrx_pkg::OP_RETFI |=> gie_o) else $error("gie not set");
  ret_flags_a: assert property (ret |=> $stable(carry_o)) else $error("return moved carry");
  ret_slow_a: assert property (ret |=> !instr_ready_o) else $error("return too short");
  lit_w_a: assert property (ret && instr_i[13:8] == rrx_pkg::OP_RETLIT_HI
    |=> wreg_o == $past(instr_i[7:0])) else $error("literal not in wreg");
  rot_w_a: assert property (rot && !instr_i[7] |=> wreg_o[0] == $past(carry_o)) else $error("carry not in bit0");
  rot_f_a: assert property (rot && instr_i[7] |=> $stable(wreg_o)) else $error("wreg hit on file rotate");
  rot_pc_a: assert property (rot |=> pc_o == $past(pc_o) + 1'b1) else $error("rotate pc wrong");
  swr_go_a: assert property (tk && instr_i == rrx_pkg::OP_RESET |-> ##[1:2] sw_reset_o) else $error("no reset");
  swr_end_a: assert property (sw_reset_o |=> !sw_reset_o ##[0:2] (pc_o == '0 && !gie_o)) else $error("reset bad");
  // main scenarios
  ret_c: cover property (ret);
  rotf_c: cover property (rot && instr_i[7]);
  swr_c: cover property (sw_reset_o);
endmodule
bind rrx_exec rrx_exec_properties i_rrx_exec_properties (.core_clk_i, .rst_i, .instr_valid_i, .instr_i,
  .instr_ready_o, .pc_o, .wreg_o, .carry_o, .gie_o, .sw_reset_o);
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the return/rotate executor
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = '0;
  logic push_i = 1'b0;
  logic [rrx_pkg::PC_W-1:0] push_addr_i = '0;
  logic [7:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic instr_ready_o;
  logic [7:0] rdata_o;
  logic [rrx_pkg::PC_W-1:0] pc_o;
  logic [7:0] wreg_o;
  logic carry_o;
  logic gie_o;
  logic sw_reset_o;
  logic unknown_op_o;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h14c2c07f;
  // 10 MHz clock
  always #50 core_clk_i = ~core_clk_i;
  rrx_exec i_rrx_exec (.core_clk_i, .rst_i, .instr_valid_i, .instr_i, .instr_ready_o, .push_i, .push_addr_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pc_o, .wreg_o, .carry_o, .gie_o, .sw_reset_o, .unknown_op_o);
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data are taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    d = rdata_o;
  endtask
  task automatic push(input logic [14:0] a);
    @(posedge core_clk_i);
    push_i <= 1'b1;
    push_addr_i <= a;
    @(posedge core_clk_i);
    push_i <= 1'b0;
  endtask
  // hold the word until taken, return in the cycle after the take
  task automatic exec(input logic [13:0] w);
    int k;
    @(posedge core_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    k = 0;
    do
    begin
      @(negedge core_clk_i);
      k++;
    end
    while (instr_ready_o !== 1'b1 && k < 20);
    @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    logic [7:0] r;
    logic [7:0] w;
    logic [6:0] f;
    logic c;
    logic [14:0] a1;
    logic [14:0] a2;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(rrx_pkg::REG_PWRCTL, r);
    chk("pwrctl", 16'(rrx_pkg::PWRCTL_RESET), 16'(r));
    exec(rrx_pkg::OP_NOP);
    chk("pc", 16'h1, 16'(pc_o));
    seed = xs(seed);
    a1 = seed[14:0];
    a2 = seed[30:16];
    push(a1);
    push(a2);
    exec({rrx_pkg::OP_RETURN_HI, 1'b0});
    chk("pc", 16'(a2), 16'(pc_o));
    w = seed[7:0] ^ seed[23:16];
    exec({rrx_pkg::OP_RETLIT_HI, w});
    chk("pc", 16'(a1), 16'(pc_o));
    chk("wreg", 16'(w), 16'(wreg_o));
    push(a2);
    exec(rrx_pkg::OP_RETFI);
    chk("pc", 16'(a2), 16'(pc_o));
    chk("gie", 16'h1, 16'(gie_o));
    c = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      f = (i == 0) ? 7'h7f : seed[6:0];
      wr({1'b1, f}, seed[15:8]);
      exec({rrx_pkg::OP_ROTL_HI, seed[16], f});
      chk("pc", 16'(a2 + 15'(i) + 15'd1), 16'(pc_o));
      chk("carry", 16'(seed[15]), 16'(carry_o));
      if (seed[16])
      begin
        rd({1'b1, f}, r);
        chk("file", 16'({seed[14:8], c}), 16'(r));
      end
      else
        w = {seed[14:8], c};
      chk("wreg", 16'(w), 16'(wreg_o));
      c = seed[15];
    end
    exec(14'h3fff);
    chk("unknown", 16'h1, 16'(unknown_op_o));
    exec(rrx_pkg::OP_RESET);
    repeat (3) @(negedge core_clk_i);
    chk("pc", 16'h0, 16'(pc_o));
    chk("gie", 16'h0, 16'(gie_o));
    rd(rrx_pkg::REG_PWRCTL, r);
    chk("ri", 16'h0, 16'(r[rrx_pkg::RI_BIT]));
    report_and_stop;
  end
  // watchdog
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
